// *** dv/rcw_asserts.sv ***
// Purpose: Checks on the byte link between master and drive
// Assumes: One clock, sync active-high reset
// Notes:   Sees only the link signals
`timescale 1ns/1ps
module rcw_asserts (
	input wire logic       CLOCK,
	input wire logic       RESET,
	input wire logic       m2s_valid,
	input wire logic       m2s_ready,
	input wire logic [7:0] m2s_data,
	input wire logic       m2s_last,
	input wire logic       s2m_valid,
	input wire logic       s2m_ready,
	input wire logic [7:0] s2m_data,
	input wire logic       s2m_last
);
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RESET);

	// --------
	// Running check of each direction
	// --------
	logic [15:0] m_crc;
	logic [15:0] s_crc;
	logic [15:0] next_m_crc;
	logic [15:0] next_s_crc;
	logic [3:0]  m_cnt;
	logic [3:0]  s_cnt;
	wire logic   m_take = m2s_valid && m2s_ready;
	wire logic   s_take = s2m_valid && s2m_ready;

	// Own fold, kept apart from the design's step
	function automatic logic [15:0] fold(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++)
			r = r[0] ? ({1'b0, r[15:1]} ^ 16'ha001) : {1'b0, r[15:1]};
		return r;
	endfunction

	always_comb next_m_crc = fold(m_crc, m2s_data);
	always_comb next_s_crc = fold(s_crc, s2m_data);

	always_ff @(posedge CLOCK) begin
		if (RESET)
			m_crc <= 16'hffff;
		else if (m_take)
			m_crc <= m2s_last ? 16'hffff : next_m_crc;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			s_crc <= 16'hffff;
		else if (s_take)
			s_crc <= s2m_last ? 16'hffff : next_s_crc;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			m_cnt <= 4'h0;
		else if (m_take)
			m_cnt <= m2s_last ? 4'h0 : m_cnt + 4'h1;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET)
			s_cnt <= 4'h0;
		else if (s_take)
			s_cnt <= s2m_last ? 4'h0 : s_cnt + 4'h1;
	end

	// --------
	// Assertions
	// --------
	AST_M2S_SPACING: assert property (m_take && !m2s_last |=> !m2s_ready [*8] ##1 m2s_ready)
		else $error("byte spacing on request channel wrong");
	AST_M2S_LAST_BUSY: assert property (m_take && m2s_last |=> !m2s_ready [*8])
		else $error("ready back too soon after last byte");
	// Check high byte stands right after check low, so only body bytes leave a gap
	AST_S2M_SPACING: assert property (s_take && s_cnt < 4'h6 |=> !s2m_valid [*8] ##1 s2m_valid)
		else $error("byte spacing on reply channel wrong");
	AST_M2S_STABLE: assert property (m2s_valid && !m2s_ready |=> m2s_valid && $stable(m2s_data) && $stable(m2s_last))
		else $error("request byte changed while waiting");
	AST_S2M_STABLE: assert property (s2m_valid && !s2m_ready |=> s2m_valid && $stable(s2m_data) && $stable(s2m_last))
		else $error("reply byte changed while waiting");
	AST_M2S_CHECK: assert property (m_take && m2s_last |-> next_m_crc == 16'h0000)
		else $error("request frame check wrong");
	AST_S2M_CHECK: assert property (s_take && s2m_last |-> next_s_crc == 16'h0000)
		else $error("reply frame check wrong");
	AST_M2S_COUNT: assert property (m_take && m2s_last |-> m_cnt == 4'h7)
		else $error("request frame not eight bytes");
	AST_S2M_COUNT: assert property (s_take && s2m_last |-> s_cnt == 4'h7)
		else $error("reply frame not eight bytes");

	cover property (m_take && m2s_last);
	cover property (s_take && s2m_last);
	cover property (m2s_valid && !m2s_ready);
endmodule

// *** dv/rtu_crc_and_command_word_tb.sv ***
// Purpose: Runs writes across the link and checks both ends
// Assumes: Device at default station, short reply timeout
// Notes:   Second link lets the bench send frames with a bad check
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %s exp %h got %h", n, e, g); end end
module rtu_crc_and_command_word_tb;
	// --------
	// Signals
	// --------
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic        req_start = 1'b0;
	logic [7:0]  req_station = 8'h00;
	logic [15:0] req_address = 16'h0000;
	logic [15:0] req_data = 16'h0000;
	logic        busy, done, ok, tmo, pw, cs, ce, pw_b, ce_b, got_ok, got_to;
	logic [7:0]  group, number;
	logic [15:0] pdata;
	logic [1:0]  run, dir, accel;
	logic [3:0]  step;
	logic [7:0]  mb [0:7];
	int          mi = 0, pw_n = 0, cs_n = 0, ce_n = 0, pwb_n = 0, ceb_n = 0;
	int          error_cnt = 0;
	int          cmp_count = 0;
	rcw_link_if  link ();
	rcw_link_if  link_b ();

	always #5 clock = ~clock;

	rcw_host #(.TIMEOUT_CYCLES(200)) rcw_host_inst (.CLOCK(clock), .RESET(reset), .LINK(link),
		.REQ_START(req_start), .REQ_STATION(req_station), .REQ_ADDRESS(req_address), .REQ_DATA(req_data),
		.BUSY(busy), .REPLY_DONE(done), .REPLY_OK(ok), .REPLY_TIMEOUT(tmo));
	rcw_device rcw_device_inst (.CLOCK(clock), .RESET(reset), .LINK(link), .PARAM_WRITE(pw),
		.PARAM_GROUP(group), .PARAM_NUMBER(number), .PARAM_DATA(pdata), .COMMAND_STROBE(cs),
		.RUN_CONTROL(run), .DIRECTION(dir), .ACCEL_SET(accel), .STEP_SELECT(step), .CRC_ERROR(ce));
	rcw_device rcw_device_inst_b (.CLOCK(clock), .RESET(reset), .LINK(link_b), .PARAM_WRITE(pw_b),
		.PARAM_GROUP(), .PARAM_NUMBER(), .PARAM_DATA(), .COMMAND_STROBE(), .RUN_CONTROL(),
		.DIRECTION(), .ACCEL_SET(), .STEP_SELECT(), .CRC_ERROR(ce_b));
	rcw_asserts rcw_asserts_inst (.CLOCK(clock), .RESET(reset), .m2s_valid(link.m2s_valid),
		.m2s_ready(link.m2s_ready), .m2s_data(link.m2s_data), .m2s_last(link.m2s_last),
		.s2m_valid(link.s2m_valid), .s2m_ready(link.s2m_ready), .s2m_data(link.s2m_data),
		.s2m_last(link.s2m_last));

	// --------
	// Monitors
	// --------
	always @(posedge clock) begin
		if (link.m2s_valid === 1'b1 && link.m2s_ready === 1'b1) begin
			mb[mi] <= link.m2s_data;
			mi <= (link.m2s_last === 1'b1) ? 0 : mi + 1;
		end
		pw_n <= pw_n + (pw === 1'b1);
		cs_n <= cs_n + (cs === 1'b1);
		ce_n <= ce_n + (ce === 1'b1);
		pwb_n <= pwb_n + (pw_b === 1'b1);
		ceb_n <= ceb_n + (ce_b === 1'b1);
	end

	// --------
	// Tasks
	// --------
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic req(input logic [7:0] st, input logic [15:0] a, input logic [15:0] d);
		@(posedge clock);
		req_start <= 1'b1;
		req_station <= st;
		req_address <= a;
		req_data <= d;
		@(posedge clock);
		req_start <= 1'b0;
		for (int n = 0; n < 1000; n++) begin
			@(posedge clock);
			if (done === 1'b1 || tmo === 1'b1)
				break;
		end
		got_ok = ok;
		got_to = tmo;
		repeat (2) @(posedge clock);
	endtask

	// Raw byte into the second device; released data is inverted
	task automatic put(input logic [7:0] b, input logic l);
		@(posedge clock);
		link_b.m2s_valid <= 1'b1;
		link_b.m2s_data <= b;
		link_b.m2s_last <= l;
		do
			@(posedge clock);
		while (link_b.m2s_ready !== 1'b1);
		link_b.m2s_valid <= 1'b0;
		link_b.m2s_data <= ~b;
		link_b.m2s_last <= 1'b0;
	endtask

	task automatic frame_b(input logic [7:0] c0, input logic [7:0] c1);
		logic [7:0] f [0:7];
		f = '{8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70, c0, c1};
		for (int k = 0; k < 8; k++)
			put(f[k], k == 7);
		repeat (20) @(posedge clock);
	endtask

	// --------
	// Tests
	// --------
	initial begin
		link_b.m2s_valid <= 1'b0;
		link_b.m2s_data <= 8'h00;
		link_b.m2s_last <= 1'b0;
		link_b.s2m_ready <= 1'b1;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		req(8'h01, 16'h0100, 16'h1770);
		`CHK("reply ok", 1'b1, got_ok)
		`CHK("no timeout", 1'b0, got_to)
		`CHK("busy", 1'b0, busy)
		`CHK("check lo", 8'h86, mb[6])
		`CHK("check hi", 8'h22, mb[7])
		`CHK("group", 8'h01, group)
		`CHK("number", 8'h00, number)
		`CHK("data", 16'h1770, pdata)
		`CHK("strobes", 0, cs_n)
		for (int i = 0; i < 16; i++) begin
			req(8'h01, 16'h2000, {4'h0, i[3:0], i[1:0], i[3:2], 2'b11, i[1:0] ^ i[3:2]});
			`CHK("run", i[1:0] ^ i[3:2], run)
			`CHK("direction", i[3:2], dir)
			`CHK("accel", i[1:0], accel)
			`CHK("step", i[3:0], step)
			`CHK("strobes", i + 1, cs_n)
			`CHK("group", 8'h20, group)
		end
		req(8'h02, 16'h0100, 16'h1234);
		`CHK("timeout", 1'b1, got_to)
		`CHK("writes", 17, pw_n)
		`CHK("errors", 0, ce_n)
		frame_b(8'h22, 8'h86);
		`CHK("swapped error", 1, ceb_n)
		`CHK("swapped write", 0, pwb_n)
		`CHK("swapped reply", 1'b0, link_b.s2m_valid)
		frame_b(8'h86, 8'h22);
		`CHK("good write", 1, pwb_n)
		`CHK("good error", 1, ceb_n)
		results();
	end

	// Whole run is near 3000 cycles
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		results();
	end
endmodule

// *** hdl/rcw_device.sv ***
// Purpose: Drive end: checks RTU frames, decodes writes, echoes replies
// Assumes: Master keeps the check and byte order on its side
// Notes:   One shift per clock, so each body byte holds off the link 8 cycles
//
// Notes on behaviour
// - Check register preset to all ones first
// - Each byte XORed into low byte
// - LSB zero: shift right, zero fill
// - LSB one: shift right, XOR A001
// - Exactly eight shifts per byte
// - Repeat per byte; final register is check
// - Check sent low byte, then high byte
// - Address high byte group, low byte number
// - Command word fields: run, direction, accel, step
`timescale 1ns/1ps
module rcw_device #(
	parameter logic [7:0] STATION = rcw_pkg::STATION_DEFAULT
) (
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	rcw_link_if.device       LINK,
	output logic             PARAM_WRITE,
	output logic [7:0]       PARAM_GROUP,
	output logic [7:0]       PARAM_NUMBER,
	output logic [15:0]      PARAM_DATA,
	output logic             COMMAND_STROBE,
	output logic [1:0]       RUN_CONTROL,
	output logic [1:0]       DIRECTION,
	output logic [1:0]       ACCEL_SET,
	output logic [3:0]       STEP_SELECT,
	output logic             CRC_ERROR
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		RX_IDLE,
		RX_SHIFT,
		RX_CHECK,
		TX_BYTE,
		TX_SHIFT,
		TX_CRC_LO,
		TX_CRC_HI
	} rcw_dev_state_e;

	rcw_dev_state_e state;
	logic [15:0]    crc;
	logic [2:0]     shift_count;
	logic [3:0]     rx_count;
	logic [2:0]     tx_index;
	logic           rx_last;
	logic [7:0]     frame [6];
	logic           rx_take;
	logic           tx_take;
	logic           frame_good;
	logic [15:0]    frame_addr;
	logic [15:0]    frame_data;
	logic [15:0]    crc_stepped;

	assign rx_take    = LINK.m2s_valid && LINK.m2s_ready;
	// Named so the low byte can be taken without selecting on a call
	assign crc_stepped = rcw_pkg::crc_step(crc);
	assign tx_take    = LINK.s2m_valid && LINK.s2m_ready;
	assign frame_addr = {frame[rcw_pkg::IDX_ADDR_HI], frame[rcw_pkg::IDX_ADDR_LO]};
	assign frame_data = {frame[rcw_pkg::IDX_DATA_HI], frame[rcw_pkg::IDX_DATA_LO]};
	// Residue of zero after the two check bytes means the check matched
	assign frame_good = (state == RX_CHECK) && (crc == rcw_pkg::CRC_RESIDUE)
		&& (rx_count == rcw_pkg::FRAME_BYTES)
		&& (frame[rcw_pkg::IDX_STATION] == STATION)
		&& (frame[rcw_pkg::IDX_FUNC] == rcw_pkg::FUNC_WRITE_SINGLE);

	// ----------------------------------------
	// Link sequencer and check register
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state          <= RX_IDLE;
			crc            <= rcw_pkg::CRC_PRESET;
			shift_count    <= 3'h0;
			rx_count       <= 4'h0;
			tx_index       <= 3'h0;
			rx_last        <= 1'b0;
			LINK.m2s_ready <= 1'b1;
			LINK.s2m_valid <= 1'b0;
			LINK.s2m_data  <= 8'h00;
			LINK.s2m_last  <= 1'b0;
		end else begin
			unique case (state)
				RX_IDLE: begin
					if (rx_take) begin
						crc            <= crc ^ {8'h00, LINK.m2s_data};
						rx_last        <= LINK.m2s_last;
						shift_count    <= 3'h0;
						LINK.m2s_ready <= 1'b0;
						state          <= RX_SHIFT;
						if (rx_count != rcw_pkg::COUNT_MAX) begin
							rx_count <= rx_count + 4'h1;
						end
					end
				end
				RX_SHIFT: begin
					crc         <= rcw_pkg::crc_step(crc);
					shift_count <= shift_count + 3'h1;
					if (shift_count == rcw_pkg::LAST_SHIFT) begin
						if (rx_last) begin
							state <= RX_CHECK;
						end else begin
							LINK.m2s_ready <= 1'b1;
							state          <= RX_IDLE;
						end
					end
				end
				RX_CHECK: begin
					crc      <= rcw_pkg::CRC_PRESET;
					rx_count <= 4'h0;
					if (frame_good) begin
						tx_index       <= 3'h0;
						LINK.s2m_valid <= 1'b1;
						LINK.s2m_data  <= frame[0];
						LINK.s2m_last  <= 1'b0;
						state          <= TX_BYTE;
					end else begin
						// Bad or foreign frame: dropped, no reply
						LINK.m2s_ready <= 1'b1;
						state          <= RX_IDLE;
					end
				end
				TX_BYTE: begin
					if (tx_take) begin
						crc            <= crc ^ {8'h00, LINK.s2m_data};
						LINK.s2m_valid <= 1'b0;
						tx_index       <= tx_index + 3'h1;
						shift_count    <= 3'h0;
						state          <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					crc         <= rcw_pkg::crc_step(crc);
					shift_count <= shift_count + 3'h1;
					if (shift_count == rcw_pkg::LAST_SHIFT) begin
						LINK.s2m_valid <= 1'b1;
						if ({1'b0, tx_index} == rcw_pkg::BODY_BYTES) begin
							// Final step result goes out low byte first
							LINK.s2m_data <= crc_stepped[7:0];
							state         <= TX_CRC_LO;
						end else begin
							LINK.s2m_data <= frame[tx_index];
							state         <= TX_BYTE;
						end
					end
				end
				TX_CRC_LO: begin
					if (tx_take) begin
						LINK.s2m_data <= crc[15:8];
						LINK.s2m_last <= 1'b1;
						state         <= TX_CRC_HI;
					end
				end
				TX_CRC_HI: begin
					if (tx_take) begin
						LINK.s2m_valid <= 1'b0;
						LINK.s2m_last  <= 1'b0;
						crc            <= rcw_pkg::CRC_PRESET;
						LINK.m2s_ready <= 1'b1;
						state          <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Frame store, body bytes only
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			for (int i = 0; i < 6; i++) begin
				frame[i] <= 8'h00;
			end
		end else if (state == RX_IDLE && rx_take && rx_count < rcw_pkg::BODY_BYTES) begin
			frame[rx_count[2:0]] <= LINK.m2s_data;
		end
	end

	// ----------------------------------------
	// Decoded outputs
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			PARAM_WRITE    <= 1'b0;
			PARAM_GROUP    <= 8'h00;
			PARAM_NUMBER   <= 8'h00;
			PARAM_DATA     <= 16'h0000;
			COMMAND_STROBE <= 1'b0;
			RUN_CONTROL    <= rcw_pkg::RUN_NONE;
			DIRECTION      <= rcw_pkg::DIR_NONE;
			ACCEL_SET      <= rcw_pkg::ACCEL_ONE;
			STEP_SELECT    <= rcw_pkg::STEP_MASTER;
			CRC_ERROR      <= 1'b0;
		end else begin
			PARAM_WRITE    <= 1'b0;
			COMMAND_STROBE <= 1'b0;
			CRC_ERROR      <= (state == RX_CHECK) && (crc != rcw_pkg::CRC_RESIDUE);
			if (frame_good) begin
				PARAM_WRITE  <= 1'b1;
				PARAM_GROUP  <= frame_addr[15:8];
				PARAM_NUMBER <= frame_addr[7:0];
				PARAM_DATA   <= frame_data;
				if (frame_addr == rcw_pkg::DRIVE_COMMAND_WORD_ADDR) begin
					// Bits 3..2 are reserved and dropped
					COMMAND_STROBE <= 1'b1;
					RUN_CONTROL    <= frame_data[rcw_pkg::RUN_LSB +: 2];
					DIRECTION      <= frame_data[rcw_pkg::DIR_LSB +: 2];
					ACCEL_SET      <= frame_data[rcw_pkg::ACCEL_LSB +: 2];
					STEP_SELECT    <= frame_data[rcw_pkg::STEP_LSB +: 4];
				end
			end
		end
	end
endmodule

// *** hdl/rcw_host.sv ***
// Purpose: Master end: builds single-write frames and checks the echo
// Assumes: Drive replies with an echo of a good write
// Notes:   No retry; a missing reply ends in a timeout pulse
`timescale 1ns/1ps
module rcw_host #(
	parameter int TIMEOUT_CYCLES = rcw_pkg::REPLY_TIMEOUT_CYCLES
) (
	input  wire logic        CLOCK,
	input  wire logic        RESET,
	rcw_link_if.host         LINK,
	input  wire logic        REQ_START,
	input  wire logic [7:0]  REQ_STATION,
	input  wire logic [15:0] REQ_ADDRESS,
	input  wire logic [15:0] REQ_DATA,
	output logic             BUSY,
	output logic             REPLY_DONE,
	output logic             REPLY_OK,
	output logic             REPLY_TIMEOUT
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0] {
		H_IDLE,
		H_BYTE,
		H_SHIFT,
		H_CRC_LO,
		H_CRC_HI,
		H_WAIT,
		H_RSHIFT
	} rcw_host_state_e;

	rcw_host_state_e state;
	logic [15:0]     crc;
	logic [2:0]      shift_count;
	logic [2:0]      tx_index;
	logic [3:0]      rx_count;
	logic            rx_last;
	logic            mismatch;
	logic [31:0]     wait_count;
	logic [7:0]      frame [6];
	logic            tx_take;
	logic            rx_take;
	logic [15:0]     crc_stepped;

	assign tx_take = LINK.m2s_valid && LINK.m2s_ready;
	assign rx_take = LINK.s2m_valid && LINK.s2m_ready;
	// Named so the low byte can be taken without selecting on a call
	assign crc_stepped = rcw_pkg::crc_step(crc);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state          <= H_IDLE;
			crc            <= rcw_pkg::CRC_PRESET;
			shift_count    <= 3'h0;
			tx_index       <= 3'h0;
			rx_count       <= 4'h0;
			rx_last        <= 1'b0;
			mismatch       <= 1'b0;
			wait_count     <= 32'h0;
			BUSY           <= 1'b0;
			REPLY_DONE     <= 1'b0;
			REPLY_OK       <= 1'b0;
			REPLY_TIMEOUT  <= 1'b0;
			LINK.m2s_valid <= 1'b0;
			LINK.m2s_data  <= 8'h00;
			LINK.m2s_last  <= 1'b0;
			LINK.s2m_ready <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				frame[i] <= 8'h00;
			end
		end else begin
			REPLY_DONE    <= 1'b0;
			REPLY_TIMEOUT <= 1'b0;
			// Timeout spans the whole reply phase, not each byte
			if (state == H_WAIT || state == H_RSHIFT) begin
				wait_count <= wait_count + 32'h1;
			end
			unique case (state)
				H_IDLE: begin
					if (REQ_START) begin
						frame[rcw_pkg::IDX_STATION] <= REQ_STATION;
						frame[rcw_pkg::IDX_FUNC]    <= rcw_pkg::FUNC_WRITE_SINGLE;
						frame[rcw_pkg::IDX_ADDR_HI] <= REQ_ADDRESS[15:8];
						frame[rcw_pkg::IDX_ADDR_LO] <= REQ_ADDRESS[7:0];
						frame[rcw_pkg::IDX_DATA_HI] <= REQ_DATA[15:8];
						frame[rcw_pkg::IDX_DATA_LO] <= REQ_DATA[7:0];
						crc            <= rcw_pkg::CRC_PRESET;
						tx_index       <= 3'h0;
						BUSY           <= 1'b1;
						LINK.m2s_valid <= 1'b1;
						LINK.m2s_data  <= REQ_STATION;
						LINK.m2s_last  <= 1'b0;
						state          <= H_BYTE;
					end
				end
				H_BYTE: begin
					if (tx_take) begin
						crc            <= crc ^ {8'h00, LINK.m2s_data};
						LINK.m2s_valid <= 1'b0;
						tx_index       <= tx_index + 3'h1;
						shift_count    <= 3'h0;
						state          <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					crc         <= rcw_pkg::crc_step(crc);
					shift_count <= shift_count + 3'h1;
					if (shift_count == rcw_pkg::LAST_SHIFT) begin
						LINK.m2s_valid <= 1'b1;
						if ({1'b0, tx_index} == rcw_pkg::BODY_BYTES) begin
							LINK.m2s_data <= crc_stepped[7:0];
							state         <= H_CRC_LO;
						end else begin
							LINK.m2s_data <= frame[tx_index];
							state         <= H_BYTE;
						end
					end
				end
				H_CRC_LO: begin
					if (tx_take) begin
						LINK.m2s_data <= crc[15:8];
						LINK.m2s_last <= 1'b1;
						state         <= H_CRC_HI;
					end
				end
				H_CRC_HI: begin
					if (tx_take) begin
						LINK.m2s_valid <= 1'b0;
						LINK.m2s_last  <= 1'b0;
						crc            <= rcw_pkg::CRC_PRESET;
						rx_count       <= 4'h0;
						mismatch       <= 1'b0;
						wait_count     <= 32'h0;
						LINK.s2m_ready <= 1'b1;
						state          <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (rx_take) begin
						crc            <= crc ^ {8'h00, LINK.s2m_data};
						rx_last        <= LINK.s2m_last;
						shift_count    <= 3'h0;
						LINK.s2m_ready <= 1'b0;
						state          <= H_RSHIFT;
						if (rx_count < rcw_pkg::BODY_BYTES && LINK.s2m_data != frame[rx_count[2:0]]) begin
							mismatch <= 1'b1;
						end
						if (rx_count != rcw_pkg::COUNT_MAX) begin
							rx_count <= rx_count + 4'h1;
						end
					end else if (wait_count >= 32'(TIMEOUT_CYCLES)) begin
						LINK.s2m_ready <= 1'b0;
						REPLY_TIMEOUT  <= 1'b1;
						BUSY           <= 1'b0;
						state          <= H_IDLE;
					end
				end
				H_RSHIFT: begin
					crc         <= rcw_pkg::crc_step(crc);
					shift_count <= shift_count + 3'h1;
					if (shift_count == rcw_pkg::LAST_SHIFT) begin
						if (rx_last) begin
							REPLY_DONE <= 1'b1;
							REPLY_OK   <= (rcw_pkg::crc_step(crc) == rcw_pkg::CRC_RESIDUE) && !mismatch
								&& (rx_count == rcw_pkg::FRAME_BYTES);
							BUSY       <= 1'b0;
							state      <= H_IDLE;
						end else begin
							LINK.s2m_ready <= 1'b1;
							state          <= H_WAIT;
						end
					end
				end
			endcase
		end
	end
endmodule

// *** include/rcw_link_if.sv ***
// Purpose: Byte stream between master and drive, one channel each way
// Assumes: Both ends on the same clock
// Notes:   last marks the final byte of a frame
`timescale 1ns/1ps
interface rcw_link_if;
	logic       m2s_valid;
	logic       m2s_ready;
	logic [7:0] m2s_data;
	logic       m2s_last;
	logic       s2m_valid;
	logic       s2m_ready;
	logic [7:0] s2m_data;
	logic       s2m_last;

	modport device (
		input  m2s_valid,
		output m2s_ready,
		input  m2s_data,
		input  m2s_last,
		output s2m_valid,
		input  s2m_ready,
		output s2m_data,
		output s2m_last
	);
	modport host (
		output m2s_valid,
		input  m2s_ready,
		output m2s_data,
		output m2s_last,
		input  s2m_valid,
		output s2m_ready,
		input  s2m_data,
		input  s2m_last
	);
endinterface

// *** include/rcw_pkg.sv ***
// Purpose: Shared constants, field layout and check step for the RTU link
// Assumes: 100 MHz system clock
// Notes:   Used by both ends of the link
package rcw_pkg;
	// ----------------------------------------
	// Check register
	// ----------------------------------------
	localparam logic [15:0] CRC_PRESET  = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'ha001;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	localparam logic [2:0]  LAST_SHIFT  = 3'h7;

	// ----------------------------------------
	// Frame layout of a single write
	// ----------------------------------------
	localparam logic [7:0]  FUNC_WRITE_SINGLE = 8'h06;
	localparam logic [3:0]  BODY_BYTES        = 4'h6;
	localparam logic [3:0]  FRAME_BYTES       = 4'h8;
	localparam logic [3:0]  COUNT_MAX         = 4'hf;
	localparam int          IDX_STATION       = 0;
	localparam int          IDX_FUNC          = 1;
	localparam int          IDX_ADDR_HI       = 2;
	localparam int          IDX_ADDR_LO       = 3;
	localparam int          IDX_DATA_HI       = 4;
	localparam int          IDX_DATA_LO       = 5;
	localparam logic [7:0]  STATION_DEFAULT   = 8'h01;

	// ----------------------------------------
	// Drive command word
	// ----------------------------------------
	localparam logic [15:0] DRIVE_COMMAND_WORD_ADDR = 16'h2000;
	localparam int          RUN_LSB    = 0;
	localparam int          DIR_LSB    = 4;
	localparam int          ACCEL_LSB  = 6;
	localparam int          STEP_LSB   = 8;
	localparam logic [1:0]  RUN_NONE   = 2'h0;
	localparam logic [1:0]  DIR_NONE   = 2'h0;
	localparam logic [1:0]  ACCEL_ONE  = 2'h0;
	localparam logic [3:0]  STEP_MASTER = 4'h0;

	// ----------------------------------------
	// Reply timeout of the master
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS      = 10;
	localparam int REPLY_TIMEOUT_NS     = 100000;
	localparam int REPLY_TIMEOUT_CYCLES = REPLY_TIMEOUT_NS / CLOCK_PERIOD_NS;

	// One right shift, polynomial folded in when the bit out is one
	function automatic logic [15:0] crc_step(input logic [15:0] c);
		logic [15:0] s;
		s = {1'b0, c[15:1]};
		return c[0] ? (s ^ CRC_POLY) : s;
	endfunction
endpackage
